// >>> hw/mel_pkg.sv
`default_nettype none

package mel_pkg;

  // Bus geometry
  localparam int unsigned APB_ADDR_W   = 12;
  localparam int unsigned APB_DATA_W   = 32;
  localparam int unsigned REG_W        = 8;
  localparam int unsigned ROW_W        = 3;

  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_ENABLE   = 8'h90;
  localparam logic [7:0]  IDX_LOG      = 8'h91;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'h92;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'h93;

  // Error reporting enable fields
  localparam int unsigned EN_SINGLE_BIT = 0;
  localparam int unsigned EN_MULTI_BIT  = 1;

  // Memory error log fields
  localparam int unsigned LOG_SB_FLAG   = 0;
  localparam int unsigned LOG_SB_ROW_LO = 1;
  localparam int unsigned LOG_MB_FLAG   = 4;
  localparam int unsigned LOG_MB_ROW_LO = 5;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_SB        = 0;
  localparam int unsigned IRQ_MB        = 1;
  localparam int unsigned IRQ_W         = 2;

  // Reset values
  localparam logic [REG_W-1:0]      ENABLE_RESET = 8'h00;
  localparam logic [IRQ_W-1:0]      IRQ_RESET    = 2'h0;
  localparam logic [ROW_W-1:0]      ROW_RESET    = 3'h0;
  localparam logic [APB_DATA_W-1:0] RDATA_ZERO   = 32'h0000_0000;

  // Byte address of a register index
  function automatic logic [APB_ADDR_W-1:0] mel_byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : mel_byte_addr

endpackage : mel_pkg

`default_nettype wire

// >>> hw/mel_error_capture.sv
`default_nettype none

module mel_error_capture
  import mel_pkg::*;
#(
  parameter int unsigned ROW_WIDTH = ROW_W
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 err_event,
  input  wire logic [ROW_WIDTH-1:0] err_row,
  input  wire logic                 flag_clear,
  output logic                      flag,
  output logic [ROW_WIDTH-1:0]      row
);

  logic                 flag_reg;
  logic [ROW_WIDTH-1:0] row_reg;

  // Sticky flag; a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clear) | err_event; // R8
    end
  end

  // Row of the most recent error of this class
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      row_reg <= ROW_WIDTH'(ROW_RESET);
    end else if (err_event) begin
      row_reg <= err_row;
    end
  end

  assign flag = flag_reg;
  assign row  = row_reg;

endmodule : mel_error_capture

`default_nettype wire

// >>> hw/mel_memory_ecc_error_logger.sv
// The APB slave port is this design's own decision.
`default_nettype none

// Summary of operation
// R1: An enabled single-bit or multi-bit memory ECC error drives the system error line.
// R2: Enable register bit 1 turns reporting of multi-bit errors on (1) or off (0).
// R3: Enable register bit 0 turns reporting of single-bit errors on (1) or off (0).
// R4: Log bits 7-5 hold the DRAM row of the last multi-bit error, valid while bit 4 is set.
// R5: Log bit 4 reads 1 once a multi-bit error has occurred, else 0.
// R6: Log bits 3-1 hold the DRAM row of the last single-bit error, valid while bit 0 is set.
// R7: Log bit 0 reads 1 once a single-bit error has occurred, else 0.
// R8: Each error flag stays set until software writes a one to it.
module mel_memory_ecc_error_logger
  import mel_pkg::*;
#(
  parameter int unsigned ROW_WIDTH = ROW_W
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [APB_DATA_W-1:0] pwdata,
  output logic      [APB_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  ecc_check_valid,
  input  wire logic                  single_bit_error,
  input  wire logic                  multi_bit_error,
  input  wire logic [ROW_WIDTH-1:0]  ecc_dram_row,
  output logic                       serr_n_out,
  output logic                       serr_n_oe_n,
  output logic                       irq
);

  logic [APB_DATA_W-1:0] prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic [REG_W-1:0]      enable_reg;
  logic [IRQ_W-1:0]      irq_stat_reg;
  logic [IRQ_W-1:0]      irq_mask_reg;
  logic                  irq_reg;
  logic                  serr_out_reg;
  logic                  serr_oe_n_reg;

  logic                  setup_phase;
  logic                  access_done;
  logic                  wr_done;
  logic                  addr_hit;
  logic                  sb_event;
  logic                  mb_event;
  logic                  sb_report;
  logic                  mb_report;
  logic                  sb_clear;
  logic                  mb_clear;
  logic                  sb_flag;
  logic                  mb_flag;
  logic [ROW_WIDTH-1:0]  sb_row;
  logic [ROW_WIDTH-1:0]  mb_row;
  logic [REG_W-1:0]      log_value;
  logic [APB_DATA_W-1:0] rdata_next;

  // Address match against a register index
  function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    return addr == mel_byte_addr(idx);
  endfunction : reg_hit

  // Bus phase decode
  assign setup_phase = psel & ~penable & ~pready_reg;
  assign access_done = psel & penable & pready_reg;
  assign wr_done     = access_done & pwrite & ~pslverr_reg;
  assign addr_hit    = reg_hit(paddr, IDX_ENABLE) | reg_hit(paddr, IDX_LOG)
                     | reg_hit(paddr, IDX_IRQ_STAT) | reg_hit(paddr, IDX_IRQ_MASK);

  // Error events and their reporting gates
  assign sb_event  = ecc_check_valid & single_bit_error;
  assign mb_event  = ecc_check_valid & multi_bit_error;
  assign sb_report = sb_event & enable_reg[EN_SINGLE_BIT]; // R3
  assign mb_report = mb_event & enable_reg[EN_MULTI_BIT];  // R2

  // Write-one-to-clear of the logged flags
  assign sb_clear = wr_done & reg_hit(paddr, IDX_LOG) & pwdata[LOG_SB_FLAG]; // R8
  assign mb_clear = wr_done & reg_hit(paddr, IDX_LOG) & pwdata[LOG_MB_FLAG]; // R8

  // Single-bit error record
  mel_error_capture #(
    .ROW_WIDTH  (ROW_WIDTH)
  ) u_single_capture (
    .clk        (clk),
    .reset_n    (reset_n),
    .err_event  (sb_event),
    .err_row    (ecc_dram_row),
    .flag_clear (sb_clear),
    .flag       (sb_flag),
    .row        (sb_row)
  );

  // Multi-bit error record
  mel_error_capture #(
    .ROW_WIDTH  (ROW_WIDTH)
  ) u_multi_capture (
    .clk        (clk),
    .reset_n    (reset_n),
    .err_event  (mb_event),
    .err_row    (ecc_dram_row),
    .flag_clear (mb_clear),
    .flag       (mb_flag),
    .row        (mb_row)
  );

  // Log layout: multi-bit row, multi-bit flag, single-bit row, single-bit flag
  always_comb begin
    log_value                                     = '0;
    log_value[LOG_MB_ROW_LO +: ROW_WIDTH]         = mb_row;  // R4
    log_value[LOG_MB_FLAG]                        = mb_flag; // R5
    log_value[LOG_SB_ROW_LO +: ROW_WIDTH]         = sb_row;  // R6
    log_value[LOG_SB_FLAG]                        = sb_flag; // R7
  end

  // Read mux; unused bits read as zero
  always_comb begin
    rdata_next = RDATA_ZERO;
    if (reg_hit(paddr, IDX_ENABLE)) begin
      rdata_next[REG_W-1:0] = enable_reg;
    end else if (reg_hit(paddr, IDX_LOG)) begin
      rdata_next[REG_W-1:0] = log_value;
    end else if (reg_hit(paddr, IDX_IRQ_STAT)) begin
      rdata_next[IRQ_W-1:0] = irq_stat_reg;
    end else if (reg_hit(paddr, IDX_IRQ_MASK)) begin
      rdata_next[IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // Ready in the first cycle of the access phase, one cycle after setup
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  // Read data and error answer captured in the setup cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg  <= RDATA_ZERO;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite ? RDATA_ZERO : rdata_next;
      pslverr_reg <= ~addr_hit;
    end else if (access_done) begin
      pslverr_reg <= 1'b0;
    end
  end

  // Error reporting enables; only bits 1:0 are implemented
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_done && reg_hit(paddr, IDX_ENABLE)) begin
      enable_reg                <= ENABLE_RESET;
      enable_reg[EN_SINGLE_BIT] <= pwdata[EN_SINGLE_BIT]; // R3
      enable_reg[EN_MULTI_BIT]  <= pwdata[EN_MULTI_BIT];  // R2
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_reg <= IRQ_RESET;
    end else begin
      irq_stat_reg[IRQ_SB] <= (irq_stat_reg[IRQ_SB]
                              & ~(wr_done & reg_hit(paddr, IDX_IRQ_STAT) & pwdata[IRQ_SB]))
                              | sb_event;
      irq_stat_reg[IRQ_MB] <= (irq_stat_reg[IRQ_MB]
                              & ~(wr_done & reg_hit(paddr, IDX_IRQ_STAT) & pwdata[IRQ_MB]))
                              | mb_event;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (wr_done && reg_hit(paddr, IDX_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // System error line: open drain, pulled low for one cycle per check with an enabled error
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serr_out_reg  <= 1'b0;
      serr_oe_n_reg <= 1'b1;
    end else begin
      serr_out_reg  <= 1'b0;
      serr_oe_n_reg <= ~(sb_report | mb_report); // R1
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign serr_n_out  = serr_out_reg;
  assign serr_n_oe_n = serr_oe_n_reg;
  assign irq         = irq_reg;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_sb_enabled;
    sb_event && enable_reg[EN_SINGLE_BIT];
  endsequence

  sequence s_mb_enabled;
    mb_event && enable_reg[EN_MULTI_BIT];
  endsequence

  sequence s_serr_pulse;
    !serr_n_oe_n && !serr_n_out;
  endsequence

  sequence s_apb_setup;
    psel && !penable && !pready;
  endsequence

  a_serr_single_bit: assert property ( // R3
    s_sb_enabled |=> s_serr_pulse)
    else $error("single-bit error did not drive the error line");

  a_serr_multi_bit: assert property ( // R2
    s_mb_enabled |=> s_serr_pulse)
    else $error("multi-bit error did not drive the error line");

  a_serr_only_enabled: assert property ( // R1
    !(sb_report || mb_report) |=> serr_n_oe_n)
    else $error("error line driven without an enabled error");

  a_mb_row_capture: assert property ( // R4
    mb_event |=> log_value[LOG_MB_ROW_LO +: ROW_WIDTH] == $past(ecc_dram_row))
    else $error("multi-bit row not captured");

  a_mb_flag_set: assert property ( // R5
    mb_event |=> log_value[LOG_MB_FLAG] ##1 log_value[LOG_MB_FLAG] || $past(mb_clear))
    else $error("multi-bit flag not set");

  a_sb_row_capture: assert property ( // R6
    sb_event |=> log_value[LOG_SB_ROW_LO +: ROW_WIDTH] == $past(ecc_dram_row))
    else $error("single-bit row not captured");

  a_sb_flag_set: assert property ( // R7
    sb_event |=> log_value[LOG_SB_FLAG])
    else $error("single-bit flag not set");

  a_flag_sticky_hold: assert property ( // R8
    sb_flag && !sb_clear |=> sb_flag)
    else $error("single-bit flag dropped without a clear");

  a_flag_clear_works: assert property ( // R8
    mb_clear && !mb_event |=> !mb_flag)
    else $error("multi-bit flag not cleared by write of one");

  a_apb_answer_time: assert property (
    s_apb_setup |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");

  // An unmapped address is refused with the answer, never silently taken
  a_apb_unmapped: assert property (
    s_apb_setup && !addr_hit |=> pready && pslverr)
    else $error("unmapped address not refused");

  // A class with reporting off must leave the error line released
  a_serr_sb_gated: assert property ( // R3
    sb_event && !enable_reg[EN_SINGLE_BIT] && !mb_report |=> serr_n_oe_n)
    else $error("disabled single-bit error drove the error line");

  a_serr_mb_gated: assert property ( // R2
    mb_event && !enable_reg[EN_MULTI_BIT] && !sb_report |=> serr_n_oe_n)
    else $error("disabled multi-bit error drove the error line");

  // A new error in the cycle of a clear keeps the flag set
  a_sb_set_wins: assert property ( // R8
    sb_event && sb_clear |=> sb_flag)
    else $error("clear beat a new single-bit error");

  a_sb_flag_clear: assert property ( // R8
    sb_clear && !sb_event |=> !sb_flag)
    else $error("single-bit flag not cleared by write of one");

  a_mb_flag_hold: assert property ( // R8
    mb_flag && !mb_clear |=> mb_flag)
    else $error("multi-bit flag dropped without a clear");

  // Level interrupt follows the unmasked status one cycle later
  a_irq_raise: assert property (
    |(irq_stat_reg & irq_mask_reg) |=> irq)
    else $error("interrupt not raised for unmasked status");

  a_irq_drop: assert property (
    !(|(irq_stat_reg & irq_mask_reg)) |=> !irq)
    else $error("interrupt high without unmasked status");

endmodule : mel_memory_ecc_error_logger

`default_nettype wire

// >>> bench/mel_serr_monitor.sv
`default_nettype none

module mel_serr_monitor (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic serr_n_out,
  input  wire logic serr_n_oe_n,
  output var  int   pulse_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic serr_wire;

  // Pull-up holds the line high while the bridge lets go of it
  assign serr_wire = serr_n_oe_n ? 1'b1 : serr_n_out;

  // Count each cycle in which the system error line is seen low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_cnt <= 0;
    end else if (serr_wire === 1'b0) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end
endmodule : mel_serr_monitor

`default_nettype wire

// >>> bench/mel_memory_ecc_error_logger_tb.sv
`default_nettype none

module mel_memory_ecc_error_logger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mel_pkg::*;

  localparam logic [11:0] A_EN = 12'h240;
  localparam logic [11:0] A_LOG = 12'h244;
  localparam logic [11:0] A_IST = 12'h248;
  localparam logic [11:0] A_MSK = 12'h24C;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;

  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        ecc_check_valid, single_bit_error, multi_bit_error;
  logic        serr_n_out, serr_n_oe_n, erv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, expv, mskv;
  logic [2:0]  ecc_dram_row, row;
  int          error_cnt, n_checks, serr_cnt, base;

  mel_memory_ecc_error_logger dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ecc_check_valid(ecc_check_valid), .single_bit_error(single_bit_error),
    .multi_bit_error(multi_bit_error), .ecc_dram_row(ecc_dram_row),
    .serr_n_out(serr_n_out), .serr_n_oe_n(serr_n_oe_n), .irq(irq));

  mel_serr_monitor sys_err (.clk(clk), .reset_n(reset_n), .serr_n_out(serr_n_out),
    .serr_n_oe_n(serr_n_oe_n), .pulse_cnt(serr_cnt));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, only the hang guard ends the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv & m, e);
  endtask : rd

  // One checked DRAM read reported on the error inputs
  task automatic ecc(input logic v, input logic sb, input logic mb, input logic [2:0] r);
    @(posedge clk);
    ecc_check_valid <= v;
    single_bit_error <= sb;
    multi_bit_error <= mb;
    ecc_dram_row <= r;
    @(posedge clk);
    ecc_check_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ecc

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {reset_n, psel, penable, pwrite, ecc_check_valid} = 5'h00;
    {single_bit_error, multi_bit_error, ecc_dram_row} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values and enable register access
    rd(A_EN, 32'h0000_0000, ALL);
    rd(A_LOG, 32'h0000_0000, 32'h0000_0011);
    rd(A_IST, 32'h0000_0000, ALL);
    wr_en: apb(1'b1, A_EN, ALL);
    rd(A_EN, 32'h0000_0003, ALL);
    apb(1'b0, 12'h250, 32'h0000_0000);
    chk({31'h0, erv}, 32'h0000_0001);
    chk(rdv, 32'h0000_0000);
    // Every enable setting against every error class
    for (int en = 0; en < 4; en++) begin
      for (int cls = 1; cls < 4; cls++) begin
        row = 3'(en + cls);
        apb(1'b1, A_LOG, 32'h0000_0011);
        apb(1'b1, A_EN, 32'(en));
        base = serr_cnt;
        ecc(1'b1, cls[0], cls[1], row);
        chk(32'(serr_cnt - base), 32'((cls[0] & en[0]) | (cls[1] & en[1])));
        expv = {24'h0, cls[1] ? row : 3'h0, 1'(cls[1]), cls[0] ? row : 3'h0, 1'(cls[0])};
        mskv = {24'h0, cls[1] ? 3'h7 : 3'h0, 1'b1, cls[0] ? 3'h7 : 3'h0, 1'b1};
        rd(A_LOG, expv, mskv);
      end
    end
    // Stickiness, ignored strobes, newest row and one-sided clears
    ecc(1'b0, 1'b1, 1'b1, 3'h1);
    rd(A_LOG, 32'h0000_00DD, ALL);
    apb(1'b1, A_LOG, 32'h0000_0001);
    rd(A_LOG, 32'h0000_00D0, 32'h0000_00F1);
    ecc(1'b1, 1'b1, 1'b0, 3'h2);
    ecc(1'b1, 1'b1, 1'b0, 3'h5);
    rd(A_LOG, 32'h0000_00DB, ALL);
    apb(1'b1, A_LOG, 32'h0000_0010);
    rd(A_LOG, 32'h0000_000B, 32'h0000_001F);
    // Clear and new single-bit error land on the same edge: the set wins
    fork
      apb(1'b1, A_LOG, 32'h0000_0001);
      begin
        @(posedge clk);
        ecc(1'b1, 1'b1, 1'b0, 3'h4);
      end
    join
    rd(A_LOG, 32'h0000_0009, 32'h0000_000F);
    // Interrupt raised, masked and cleared
    apb(1'b1, A_IST, 32'h0000_0003);
    apb(1'b1, A_MSK, 32'h0000_0001);
    rd(A_MSK, 32'h0000_0001, ALL);
    ecc(1'b1, 1'b0, 1'b1, 3'h3);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(A_IST, 32'h0000_0002, ALL);
    apb(1'b1, A_MSK, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, A_IST, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    // Mid-run reset wipes flags, rows and enables
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk({31'h0, irq}, 32'h0000_0000);
    rd(A_LOG, 32'h0000_0000, ALL);
    rd(A_EN, 32'h0000_0000, ALL);
    report_and_stop();
  end
endmodule : mel_memory_ecc_error_logger_tb

`default_nettype wire
